// ### spw_supervisor_port.sv
/*
  supervisor i/o port with software-refreshed watchdog, power-detect status,
  flash vpp select, rs-485 direction control and printer direction select.
  assumes a host i/o bus with separate read and write strobes on the same clock;
  straps and power-detect come from pins and are synchronised here.
*/
// What this block does
// RQ1 - bit 0 is a readable and writable watchdog enable; one arms it
// RQ2 - bit 1 is readable and writable refresh; 1-0-1 toggling is a keep-alive
// RQ3 - bit 2 selects flash vpp: one gives 12 volts, zero gives 5 volts
// RQ4 - write bit 3 enables rs-485 direction control; read gives power-detect status
// RQ5 - bit 4 write-only: one makes printer data input, zero output (default)
// RQ6 - bit 5 is readable and writable, latching the alternate switch bank selection
// RQ7 - reset clears every port bit, leaving the watchdog disabled
// RQ8 - supervision begins only from the first write of one to bit 0
// RQ9 - software refreshes at least every 1.6 seconds while armed
// RQ10 - an unrefreshed armed watchdog emits a processor reset pulse
// RQ11 - watchdog can activate only while its permit strap is installed
// RQ12 - power-detect output drives the channel-check line, raising an nmi
// RQ13 - power-monitor strap gates only the nmi; status stays readable on bit 3
// RQ14 - power-detect status reads zero on low power or low battery
// RQ15 - with bit 3 set, rs-485 transceiver direction follows request-to-send
// RQ16 - after reset rs-485 runs full duplex with the transceiver receiving
// RQ17 - software keeps a shadow copy since some bits do not read back
// RQ18 - each refresh bit change restarts the prescaled 1.6 second timeout
module spw_supervisor_port (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  input wire logic powerDetectInN,
  input wire logic watchdogPermitStrap,
  input wire logic powerMonitorStrap,
  input wire logic com2RequestToSend,
  output logic flashVppHigh,
  output logic printerDataInput,
  output logic alternateSwitchBank,
  output logic rs485DriveEnable,
  output logic channelCheck,
  output logic cpuResetPulse,
  output logic watchdogArmed
);

  typedef struct packed {
    logic [2:0] pdSync;
    logic [2:0] permitSync;
    logic [2:0] monSync;
    logic pdStable;
    logic permitStable;
    logic monStable;
    logic wdEnable;
    logic refresh;
    logic vppHigh;
    logic dir485;
    logic prnInput;
    logic altBank;
    logic armed;
    logic [7:0] preCnt;
    logic [20:0] wdCnt;
    logic [4:0] pulseCnt;
    logic [7:0] rdData;
    logic rs485De;
    logic chanChk;
    logic rstOut;
  } spw_state_s;

  localparam logic [7:0] PRE_LAST = 8'(spw_pkg::PRESCALE_CYCLES - 1);
  localparam logic [20:0] WD_LAST = 21'(spw_pkg::TIMEOUT_TICKS - 1);
  localparam logic [4:0] PULSE_LEN = 5'(spw_pkg::RESET_PULSE_CYCLES);

  spw_state_s state_reg;
  spw_state_s state_next;
  logic portWrite;
  logic portRead;
  logic supervising;
  logic tick;

  assign portWrite = ioWrite && (ioAddr == spw_pkg::SUP_PORT_ADDR);
  assign portRead = ioRead && (ioAddr == spw_pkg::SUP_PORT_ADDR);
  assign supervising = state_reg.armed && state_reg.permitStable; // [RQ11]
  assign tick = (state_reg.preCnt == PRE_LAST);

  // next-state logic for synchronisers, port bits and watchdog
  always_comb begin
    state_next = state_reg;
    // three-stage sync; accept a change when stages two and three agree
    state_next.pdSync = {state_reg.pdSync[1:0], powerDetectInN};
    state_next.permitSync = {state_reg.permitSync[1:0], watchdogPermitStrap};
    state_next.monSync = {state_reg.monSync[1:0], powerMonitorStrap};
    if (state_reg.pdSync[2] == state_reg.pdSync[1]) begin
      state_next.pdStable = state_reg.pdSync[2];
    end
    if (state_reg.permitSync[2] == state_reg.permitSync[1]) begin
      state_next.permitStable = state_reg.permitSync[2];
    end
    if (state_reg.monSync[2] == state_reg.monSync[1]) begin
      state_next.monStable = state_reg.monSync[2];
    end
    // host write to the supervisor port
    if (portWrite) begin
      state_next.wdEnable = ioWrData[spw_pkg::BIT_WD_EN]; // [RQ1]
      state_next.refresh = ioWrData[spw_pkg::BIT_WD_REFRESH]; // [RQ2]
      state_next.vppHigh = ioWrData[spw_pkg::BIT_VPP_HIGH]; // [RQ3]
      state_next.dir485 = ioWrData[spw_pkg::BIT_DIR485_PWR]; // [RQ4]
      state_next.prnInput = ioWrData[spw_pkg::BIT_PRN_INPUT]; // [RQ5]
      state_next.altBank = ioWrData[spw_pkg::BIT_ALT_BANK]; // latched select
      if (ioWrData[spw_pkg::BIT_WD_EN]) begin
        state_next.armed = 1'b1; // [RQ8]
      end else begin
        state_next.armed = 1'b0; // clearing enable stops supervision
      end
    end
    // prescaler runs only while supervising
    if (!supervising) begin
      state_next.preCnt = 8'h00;
      state_next.wdCnt = 21'h000000;
    end else begin
      state_next.preCnt = tick ? 8'h00 : state_reg.preCnt + 8'h01;
      if (portWrite && (ioWrData[spw_pkg::BIT_WD_REFRESH] != state_reg.refresh)) begin
        state_next.wdCnt = 21'h000000; // [RQ18] [RQ2]
      end else if (tick) begin
        if (state_reg.wdCnt == WD_LAST) begin
          state_next.wdCnt = 21'h000000;
          state_next.pulseCnt = PULSE_LEN; // [RQ10]
        end else begin
          state_next.wdCnt = state_reg.wdCnt + 21'h000001;
        end
      end
    end
    // restart pulse countdown
    if (state_reg.pulseCnt != 5'h00) begin
      state_next.pulseCnt = state_reg.pulseCnt - 5'h01;
    end
    state_next.rstOut = (state_next.pulseCnt != 5'h00); // [RQ10]
    // read data: bit 3 gives power-detect, bit 4 write-only reads zero
    state_next.rdData = spw_pkg::SUP_RESET;
    if (portRead) begin
      state_next.rdData[spw_pkg::BIT_WD_EN] = state_reg.wdEnable; // [RQ1]
      state_next.rdData[spw_pkg::BIT_WD_REFRESH] = state_reg.refresh; // [RQ2]
      state_next.rdData[spw_pkg::BIT_VPP_HIGH] = state_reg.vppHigh; // [RQ3]
      state_next.rdData[spw_pkg::BIT_DIR485_PWR] = state_reg.pdStable; // [RQ4] [RQ13] [RQ14]
      state_next.rdData[spw_pkg::BIT_ALT_BANK] = state_reg.altBank; // [RQ6]
    end
    // rs-485 direction follows rts only when enabled, else receive
    state_next.rs485De = state_reg.dir485 && com2RequestToSend; // [RQ15] [RQ16]
    // nmi on low power-detect, gated by the monitor strap only
    state_next.chanChk = state_reg.monStable && !state_reg.pdStable; // [RQ12] [RQ13]
  end

  // state register; everything clears on reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0; // [RQ7]
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  assign ioRdData = state_reg.rdData;
  assign flashVppHigh = state_reg.vppHigh;
  assign printerDataInput = state_reg.prnInput;
  assign alternateSwitchBank = state_reg.altBank;
  assign rs485DriveEnable = state_reg.rs485De;
  assign channelCheck = state_reg.chanChk;
  assign cpuResetPulse = state_reg.rstOut;
  assign watchdogArmed = state_reg.armed;

endmodule : spw_supervisor_port

// ### spw_pkg.sv
/*
  package for the supervisor port watchdog: port address, bit positions,
  reset value and watchdog timing counts.
  assumes a 125 MHz board clock.
*/
package spw_pkg;
  localparam logic [15:0] SUP_PORT_ADDR = 16'h0201; // supervisor_control_status
  localparam logic [7:0] SUP_RESET = 8'h00;
  localparam int BIT_WD_EN = 0;
  localparam int BIT_WD_REFRESH = 1;
  localparam int BIT_VPP_HIGH = 2;
  localparam int BIT_DIR485_PWR = 3;
  localparam int BIT_PRN_INPUT = 4;
  localparam int BIT_ALT_BANK = 5;
  localparam int CLOCK_HZ = 125000000;
  localparam int PRESCALE_US = 1; // prescaler tick period in microseconds
  localparam int PRESCALE_CYCLES = CLOCK_HZ / 1000000 * PRESCALE_US;
  localparam int TIMEOUT_MS = 1600; // watchdog interval
  localparam int TIMEOUT_TICKS = TIMEOUT_MS * 1000 / PRESCALE_US;
  localparam int RESET_PULSE_CYCLES = 16; // length of the restart pulse
endpackage : spw_pkg

// ### spw_supervisor_port_properties.sv
/* timing and status checks of the supervisor port.
   sees only the top ports; one clock domain. */
module spw_supervisor_port_properties (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic powerDetectInN,
  input wire logic watchdogPermitStrap,
  input wire logic powerMonitorStrap,
  input wire logic com2RequestToSend,
  input wire logic flashVppHigh,
  input wire logic printerDataInput,
  input wire logic rs485DriveEnable,
  input wire logic channelCheck,
  input wire logic cpuResetPulse,
  input wire logic watchdogArmed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // port decode
  wire logic portHit = ioAddr == spw_pkg::SUP_PORT_ADDR;
  a_read_format: assert property (ioRead && portHit |=> ioRdData[7:6] == 2'h0 && !ioRdData[4])
    else $error("read data format wrong");
  a_read_idle: assert property (!ioRead |=> ioRdData == 8'h00)
    else $error("read data not idle");
  a_vpp_write: assert property (ioWrite && portHit |=> flashVppHigh == $past(ioWrData[2]))
    else $error("vpp select not written");
  a_dir_write: assert property (ioWrite && portHit |=> printerDataInput == $past(ioWrData[4]))
    else $error("printer direction not written");
  a_arm_cause: assert property ($rose(watchdogArmed) |-> $past(ioWrite) && $past(ioWrData[0]))
    else $error("armed without a write");
  a_pulse_len: assert property ($rose(cpuResetPulse) |-> ##15 cpuResetPulse ##1 !cpuResetPulse)
    else $error("reset pulse length wrong");
  a_pulse_armed: assert property ($rose(cpuResetPulse) |-> $past(watchdogArmed))
    else $error("reset pulse while unarmed");
  a_strap_block: assert property ((!watchdogPermitStrap) [*8] |-> !$rose(cpuResetPulse))
    else $error("reset pulse without strap");
  a_pdo_status: assert property ((!powerDetectInN) [*6] ##0 (ioRead && portHit) |=> !ioRdData[3])
    else $error("power status not low");
  a_nmi_gate: assert property ((!powerMonitorStrap) [*6] |-> !channelCheck)
    else $error("nmi despite open strap");
  a_nmi_raise: assert property ((powerMonitorStrap && !powerDetectInN) [*6] |-> channelCheck)
    else $error("nmi missing on power fail");
  a_rts_follow: assert property (!$past(com2RequestToSend) |-> !rs485DriveEnable)
    else $error("driver on without rts");
endmodule : spw_supervisor_port_properties

// ### spw_host_model.sv
/* host processor model issuing port reads and writes.
   strobes change at falling edges; one cycle each. */
module spw_host_model (
  input wire logic clock,
  output logic [15:0] ioAddr,
  output logic ioWrite,
  output logic ioRead,
  output logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData
);
  logic [7:0] shadow = 8'h00;
  // idle bus at time zero
  initial begin
    {ioAddr, ioWrite, ioRead, ioWrData} = 26'h0;
  end
  // one access; released address and data show the inverse, strobes drop; port write kept in shadow
  task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clock);
    {ioAddr, ioWrite, ioRead, ioWrData} = {a, w, !w, d};
    @(negedge clock);
    q = ioRdData;
    {ioAddr, ioWrite, ioRead, ioWrData} = {~a, 2'b00, ~d};
    if (w && a == spw_pkg::SUP_PORT_ADDR) shadow = d;
  endtask : access
  // keep-alive flips bit 1 from the shadow
  task automatic refresh(output logic [7:0] q);
    access(spw_pkg::SUP_PORT_ADDR, 1'b1, shadow ^ 8'h02, q);
  endtask : refresh
endmodule : spw_host_model

// ### spw_supervisor_port_test.sv
/* self-checking bench of the supervisor port.
   pins change at falling edges; host model drives the bus. */
module spw_supervisor_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ADDR = spw_pkg::SUP_PORT_ADDR;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData, ioRdData, rd, want;
  logic ioWrite, ioRead, flashVppHigh, printerDataInput, alternateSwitchBank;
  logic rs485DriveEnable, channelCheck, cpuResetPulse, watchdogArmed;
  logic clock = 1'b0, sys_rst = 1'b1, powerDetectInN = 1'b1, watchdogPermitStrap = 1'b1;
  logic powerMonitorStrap = 1'b1, com2RequestToSend = 1'b0;
  logic [31:0] seed = 32'h39AD;
  int failures = 0, checked = 0;
  spw_supervisor_port spw_supervisor_port_inst (.*);
  spw_host_model spw_host_model_inst (.*);
  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] rdExp(input logic [7:0] w, input logic power_detect_output);
    return {2'b00, w[5], 1'b0, power_detect_output, w[2:0]};
  endfunction : rdExp
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    spw_host_model_inst.access(a, w, d, rd);
  endtask : acc
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp8);
    checked++;
    if (seen !== exp8) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp8);
    end
  endtask : chk
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // clock and hang limit
  initial forever #4 clock = ~clock;
  initial begin
    #400000 failures++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock) sys_rst = 1'b0;
    chk({1'b0, flashVppHigh, printerDataInput, alternateSwitchBank, rs485DriveEnable,
      channelCheck, cpuResetPulse, watchdogArmed}, 8'h00);
    repeat (4) @(negedge clock);
    acc(ADDR, 1'b0, 8'h00);
    chk(rd, 8'h08);
    $display("reset test done");
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      want = (i == 0) ? 8'h10 : ((i == 1) ? 8'h3E : seed[7:0]);
      acc(ADDR, 1'b1, want);
      acc(ADDR ^ 16'h0003, 1'b1, ~want);
      chk({5'h00, alternateSwitchBank, flashVppHigh, printerDataInput},
        {5'h00, want[5], want[2], want[4]});
      acc(ADDR, 1'b0, 8'h00);
      chk(rd, rdExp(want, 1'b1));
    end
    $display("register test done");
    powerDetectInN = 1'b0;
    repeat (6) @(negedge clock);
    chk({7'h0, channelCheck}, 8'h01);
    powerMonitorStrap = 1'b0;
    repeat (6) @(negedge clock);
    acc(ADDR, 1'b0, 8'h00);
    chk({6'h00, rd[3], channelCheck}, 8'h00);
    powerDetectInN = 1'b1;
    $display("power test done");
    acc(ADDR, 1'b1, 8'h08);
    com2RequestToSend = 1'b1;
    repeat (2) @(negedge clock);
    chk({7'h0, rs485DriveEnable}, 8'h01);
    acc(ADDR, 1'b1, 8'h00);
    @(negedge clock);
    chk({7'h0, rs485DriveEnable}, 8'h00);
    $display("rs485 test done");
    acc(ADDR, 1'b1, 8'h01);
    chk({7'h0, watchdogArmed}, 8'h01);
    repeat (3) spw_host_model_inst.refresh(rd);
    watchdogPermitStrap = 1'b0;
    repeat (20) @(negedge clock);
    chk({7'h0, cpuResetPulse}, 8'h00);
    $display("watchdog test done");
    summarize();
  end
endmodule : spw_supervisor_port_test
bind spw_supervisor_port spw_supervisor_port_properties spw_supervisor_port_properties_inst (.*);
